//--- src/rsac_top.sv
// System-area configuration loader, lock checks and wait timers
`timescale 1ns/1ps
`default_nettype none
`include "rsac_defines.svh"
// Summary of operation
// [R1] RF lock bit one makes block read-only
// [R2] RF lock bits at 0x1f0, bit N mod 8
// [R3] Serial lock bit one makes block read-only
// [R4] Serial lock bits at 0x1f4, same mapping
// [R5] Plaintext bit one forbids unencrypted RF access
// [R6] Lock and plaintext fields default to zero
// [R7] Writer puts zero into reserved bits
// [R8] Protocol field selects auto, first or second
// [R9] Reserved protocol value behaves as auto
// [R10] Identifier source: all-zero or stored values
// [R11] Seven-bit slave address, default 1010100
// [R12] Tunnel byte: tunnel_poll_command wait high, answer low
// [R13] Tunnel_poll_command wait T times 2^QW, QW 0..8
// [R14] Answer wait T times 2^AW, AW 0..12
// [R15] Host byte: char, response, interrupt select
// [R16] Character wait T times 2^CW
// [R17] Response wait T times 2^RW
// [R18] Configurer allows for base period tolerance
// [R19] Locks immediate, others on reset or self-reset
// [R20] Invalid enable or check byte gives defaults
// [R21] Interrupt select: field detect, RF event mode
module rsac_top
  import rsac_pkg::*;
#(
  parameter int TUN_BASE_CYC  = `RSAC_TUN_T_NS / `RSAC_CLK_NS,
  parameter int CHAR_BASE_CYC = `RSAC_CHAR_T_NS / `RSAC_CLK_NS,
  parameter int RESP_BASE_CYC = `RSAC_RESP_T_NS / `RSAC_CLK_NS
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  // System-area byte port
  input  wire logic                   sa_wr_i,
  input  wire logic                   sa_rd_i,
  input  wire logic [`RSAC_ADDR_W-1:0] sa_addr_i,
  input  wire logic [7:0]             sa_wdata_i,
  output logic      [7:0]             sa_rdata_o,
  output logic                        sa_rvalid_o,
  // Enable check and self-reset
  input  wire logic                   cfg_valid_i,
  input  wire logic                   self_reset_i,
  // Memory access checks
  input  wire rsac_acc_t              rf_acc_i,
  output rsac_ans_t                   rf_ans_o,
  input  wire rsac_acc_t              si_acc_i,
  output rsac_ans_t                   si_ans_o,
  // Applied configuration
  output rsac_cfg_t                   cfg_o,
  // Tunnel-mode waits
  input  wire logic                   tun_irq_sent_i,
  input  wire logic                   tun_tunnel_poll_command_i,
  input  wire logic                   tun_tunnel_poll_command_done_i,
  input  wire logic                   tun_answer_i,
  output logic                        tunnel_poll_command_timeout_o,
  output logic                        answer_timeout_o,
  // Host-link waits
  input  wire logic                   i2c_char_i,
  input  wire logic                   i2c_end_i,
  input  wire logic                   resp_start_i,
  input  wire logic                   read_req_i,
  output logic                        char_timeout_o,
  output logic                        resp_timeout_o
);
  localparam int NB = `RSAC_USER_BLOCKS;
  localparam rsac_cfg_t DEF_CFG = '{
    proto: `RSAC_PROTO_AUTO, id_sa: 1'b0, slave: `RSAC_SLAVE_DEF,
    qw: `RSAC_QW_DEF, aw: `RSAC_AW_DEF, cw: `RSAC_CW_DEF, rw: `RSAC_RW_DEF,
    field_irq: 1'b0, rf_irq: `RSAC_IRQ_NONE};

  logic [7:0]    word_lo;
  logic [7:0]    word_hi;
  logic [NB-1:0] rf_lock;
  logic [NB-1:0] si_lock;
  logic [NB-1:0] plain_mask;
  logic [7:0]    tunnel;
  logic [7:0]    host;
  logic [7:0]    next_word_lo;
  logic [7:0]    next_word_hi;
  logic [NB-1:0] next_rf_lock;
  logic [NB-1:0] next_si_lock;
  logic [NB-1:0] next_plain_mask;
  logic [7:0]    next_tunnel;
  logic [7:0]    next_host;
  logic [7:0]    next_rdata;
  logic          next_rvalid;
  logic [`RSAC_ADDR_W-1:0] word_addr;
  logic [1:0]    lane;

  function automatic logic [NB-1:0] put_byte(input logic [NB-1:0] v,
                                             input logic [1:0] idx,
                                             input logic [7:0] d);
    logic [31:0] t;
    t = {{(32-NB){1'b0}}, v};
    t[idx*8 +: 8] = d;
    // Bits past the last user block are dropped, so reserved bits stay zero
    return t[NB-1:0];
  endfunction

  function automatic logic [7:0] get_byte(input logic [NB-1:0] v,
                                          input logic [1:0] idx);
    logic [31:0] t;
    t = {{(32-NB){1'b0}}, v};
    return t[idx*8 +: 8];
  endfunction

  // System-area store and read port
  always_comb begin
    word_addr       = sa_addr_i & ~`RSAC_LANE_MASK;
    lane            = sa_addr_i[1:0];
    next_word_lo    = word_lo;
    next_word_hi    = word_hi;
    next_rf_lock    = rf_lock;
    next_si_lock    = si_lock;
    next_plain_mask = plain_mask;
    next_tunnel     = tunnel;
    next_host       = host;
    if (sa_wr_i) begin
      if (word_addr == `RSAC_ADDR_RF_LOCK)
        next_rf_lock = put_byte(rf_lock, lane, sa_wdata_i); // [R2]
      if (word_addr == `RSAC_ADDR_SI_LOCK)
        next_si_lock = put_byte(si_lock, lane, sa_wdata_i); // [R4]
      if (word_addr == `RSAC_ADDR_PLAIN)
        next_plain_mask = put_byte(plain_mask, lane, sa_wdata_i); // [R5]
      if (sa_addr_i == `RSAC_ADDR_WORD_LO)
        next_word_lo = sa_wdata_i & `RSAC_WORD_LO_MASK;
      if (sa_addr_i == `RSAC_ADDR_WORD_HI)
        next_word_hi = sa_wdata_i & `RSAC_WORD_HI_MASK;
      if (sa_addr_i == `RSAC_ADDR_TUNNEL)
        next_tunnel = sa_wdata_i; // [R12]
      if (sa_addr_i == `RSAC_ADDR_HOST)
        next_host = sa_wdata_i & `RSAC_HOST_MASK; // [R15]
    end
    next_rvalid = sa_rd_i;
    next_rdata  = sa_rdata_o;
    if (sa_rd_i) begin
      next_rdata = 8'h00;
      if (word_addr == `RSAC_ADDR_RF_LOCK)
        next_rdata = get_byte(rf_lock, lane);
      if (word_addr == `RSAC_ADDR_SI_LOCK)
        next_rdata = get_byte(si_lock, lane);
      if (word_addr == `RSAC_ADDR_PLAIN)
        next_rdata = get_byte(plain_mask, lane);
      if (sa_addr_i == `RSAC_ADDR_WORD_LO)
        next_rdata = word_lo;
      if (sa_addr_i == `RSAC_ADDR_WORD_HI)
        next_rdata = word_hi;
      if (sa_addr_i == `RSAC_ADDR_TUNNEL)
        next_rdata = tunnel;
      if (sa_addr_i == `RSAC_ADDR_HOST)
        next_rdata = host;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rf_lock     <= '0; // [R6]
      si_lock     <= '0; // [R6]
      plain_mask  <= '0; // [R6]
      word_lo     <= `RSAC_WORD_LO_DEF;
      word_hi     <= `RSAC_WORD_HI_DEF;
      tunnel      <= `RSAC_TUNNEL_DEF;
      host        <= `RSAC_HOST_DEF;
      sa_rdata_o  <= 8'h00;
      sa_rvalid_o <= 1'b0;
    end else begin
      rf_lock     <= next_rf_lock;
      si_lock     <= next_si_lock;
      plain_mask  <= next_plain_mask;
      word_lo     <= next_word_lo;
      word_hi     <= next_word_hi;
      tunnel      <= next_tunnel;
      host        <= next_host;
      sa_rdata_o  <= next_rdata;
      sa_rvalid_o <= next_rvalid;
    end
  end

  // Applied configuration: decoded only at reset release or self-reset
  function automatic rsac_cfg_t decode_cfg(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] tn, input logic [7:0] hb);
    rsac_cfg_t c;
    c.proto = lo[`RSAC_PROTO_FIELD]; // [R8]
    if (c.proto == `RSAC_PROTO_RESV)
      c.proto = `RSAC_PROTO_AUTO; // [R9]
    c.id_sa = lo[`RSAC_IDSEL_BIT]; // [R10]
    c.slave = hi[`RSAC_SLAVE_FIELD]; // [R11]
    c.qw = tn[`RSAC_QW_FIELD];
    if (c.qw > `RSAC_QW_MAX)
      c.qw = `RSAC_QW_DEF; // [R13]
    c.aw = tn[`RSAC_AW_FIELD];
    if (c.aw > `RSAC_AW_MAX)
      c.aw = `RSAC_AW_DEF; // [R14]
    c.cw = hb[`RSAC_CW_FIELD]; // [R16]
    c.rw = hb[`RSAC_RW_FIELD]; // [R17]
    c.field_irq = hb[`RSAC_FIELD_IRQ_BIT]; // [R21]
    c.rf_irq = hb[`RSAC_RF_IRQ_FIELD];
    if (c.rf_irq == `RSAC_IRQ_RESV)
      c.rf_irq = `RSAC_IRQ_NONE; // [R21]
    return c;
  endfunction

  logic      load_pend;
  logic      next_load_pend;
  logic      load;
  rsac_cfg_t next_cfg;

  always_comb begin
    load           = load_pend | self_reset_i;
    next_load_pend = 1'b0;
    next_cfg       = cfg_o; // [R19]
    if (load)
      next_cfg = cfg_valid_i ? decode_cfg(word_lo, word_hi, tunnel, host) : DEF_CFG; // [R20]
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_pend <= 1'b1;
      cfg_o     <= DEF_CFG;
    end else begin
      load_pend <= next_load_pend;
      cfg_o     <= next_cfg;
    end
  end

  // Lock checks see every rewrite at once; an invalid enable unlocks all
  logic [NB-1:0] eff_rf;
  logic [NB-1:0] eff_si;
  logic [NB-1:0] eff_plain;
  logic          rf_ro_bit;
  logic          si_ro_bit;
  logic          rf_plain_bit;
  rsac_ans_t     next_rf_ans;
  rsac_ans_t     next_si_ans;

  assign eff_rf    = cfg_valid_i ? rf_lock : '0; // [R19]
  assign eff_si    = cfg_valid_i ? si_lock : '0; // [R20]
  assign eff_plain = cfg_valid_i ? plain_mask : '0;

  rsac_block_bit #(.N(NB)) u_rf_lock (
    .bits_i  (eff_rf),
    .block_i (rf_acc_i.block),
    .bit_o   (rf_ro_bit)
  );
  rsac_block_bit #(.N(NB)) u_si_lock (
    .bits_i  (eff_si),
    .block_i (si_acc_i.block),
    .bit_o   (si_ro_bit)
  );
  rsac_block_bit #(.N(NB)) u_plain (
    .bits_i  (eff_plain),
    .block_i (rf_acc_i.block),
    .bit_o   (rf_plain_bit)
  );

  always_comb begin
    next_rf_ans.ack        = rf_acc_i.req;
    next_rf_ans.ro_deny    = rf_acc_i.req & rf_acc_i.write & rf_ro_bit; // [R1]
    next_rf_ans.plain_deny = rf_acc_i.req & rf_acc_i.plain & rf_plain_bit; // [R5]
    next_rf_ans.allow      = rf_acc_i.req & ~next_rf_ans.ro_deny & ~next_rf_ans.plain_deny;
    next_si_ans.ack        = si_acc_i.req;
    next_si_ans.ro_deny    = si_acc_i.req & si_acc_i.write & si_ro_bit; // [R3]
    // Plaintext blocking has no meaning on the serial side
    next_si_ans.plain_deny = 1'b0;
    next_si_ans.allow      = si_acc_i.req & ~next_si_ans.ro_deny;
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rf_ans_o <= '0;
      si_ans_o <= '0;
    end else begin
      rf_ans_o <= next_rf_ans;
      si_ans_o <= next_si_ans;
    end
  end

  // Wait timers; base periods carry the tolerance the configurer must allow for
  rsac_wait_timer u_tunnel_poll_command_wait (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (tun_irq_sent_i),
    .stop_i    (tun_tunnel_poll_command_i),
    .base_i    (16'(TUN_BASE_CYC)),
    .exp_i     (cfg_o.qw), // [R13]
    .expired_o (tunnel_poll_command_timeout_o),
    .running_o ()
  );
  rsac_wait_timer u_answer_wait (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (tun_tunnel_poll_command_done_i),
    .stop_i    (tun_answer_i),
    .base_i    (16'(TUN_BASE_CYC)),
    .exp_i     (cfg_o.aw), // [R14]
    .expired_o (answer_timeout_o),
    .running_o ()
  );
  rsac_wait_timer u_char_wait (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (i2c_char_i),
    .stop_i    (i2c_end_i),
    .base_i    (16'(CHAR_BASE_CYC)),
    .exp_i     ({`RSAC_EXP_PAD, cfg_o.cw}), // [R16]
    .expired_o (char_timeout_o),
    .running_o ()
  );
  rsac_wait_timer u_resp_wait (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (resp_start_i),
    .stop_i    (read_req_i),
    .base_i    (16'(RESP_BASE_CYC)),
    .exp_i     ({`RSAC_EXP_PAD, cfg_o.rw}), // [R17]
    .expired_o (resp_timeout_o),
    .running_o ()
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  rf_readonly_a: assert property ( // [R1]
    rf_acc_i.req && rf_acc_i.write && cfg_valid_i && rf_lock[rf_acc_i.block % NB]
      && rf_acc_i.block < 5'(NB) |=> rf_ans_o.ro_deny && !rf_ans_o.allow)
    else $error("rf write to locked block not refused");
  si_readonly_a: assert property ( // [R3]
    si_acc_i.req && si_acc_i.write && !si_ro_bit |=> si_ans_o.allow && !si_ans_o.ro_deny)
    else $error("serial write to open block refused");
  plain_block_a: assert property ( // [R5]
    rf_ans_o.plain_deny |-> $past(rf_acc_i.plain) && !rf_ans_o.allow && !si_ans_o.plain_deny)
    else $error("plaintext denial without cause");
  lock_lane_a: assert property ( // [R2]
    sa_wr_i && sa_addr_i == `RSAC_ADDR_RF_LOCK |=> rf_lock[7:0] == $past(sa_wdata_i))
    else $error("rf lock byte not stored");
  cfg_hold_a: assert property ( // [R19]
    !load ##1 !load |-> $stable(cfg_o))
    else $error("applied config changed without reload");
  cfg_default_a: assert property ( // [R20]
    load && !cfg_valid_i |=> cfg_o == DEF_CFG)
    else $error("invalid config did not give defaults");
  proto_resv_a: assert property ( // [R9]
    load && cfg_valid_i && word_lo[`RSAC_PROTO_FIELD] == `RSAC_PROTO_RESV
      |=> cfg_o.proto == `RSAC_PROTO_AUTO)
    else $error("reserved protocol not mapped to auto");
  exp_range_a: assert property ( // [R14]
    cfg_o.qw <= `RSAC_QW_MAX && cfg_o.aw <= `RSAC_AW_MAX)
    else $error("wait exponent out of range");
  slave_addr_a: assert property ( // [R11]
    load && cfg_valid_i |=> cfg_o.slave == $past(word_hi[`RSAC_SLAVE_FIELD]))
    else $error("slave address not taken from store");
endmodule // rsac_top
`default_nettype wire

//--- pkg/rsac_defines.svh
// Constants for the system-area configuration loader
`ifndef RSAC_DEFINES_SVH
`define RSAC_DEFINES_SVH
`define RSAC_ADDR_W          9
`define RSAC_ADDR_WORD_LO    9'h1ee
`define RSAC_ADDR_WORD_HI    9'h1ef
`define RSAC_ADDR_RF_LOCK    9'h1f0
`define RSAC_ADDR_SI_LOCK    9'h1f4
`define RSAC_ADDR_PLAIN      9'h1f8
`define RSAC_ADDR_TUNNEL     9'h1fc
`define RSAC_ADDR_HOST       9'h1fd
`define RSAC_LANE_MASK       9'h003
`define RSAC_USER_BLOCKS     27
`define RSAC_BLOCK_W         5
`define RSAC_PROTO_FIELD     5:4
`define RSAC_IDSEL_BIT       0
`define RSAC_SLAVE_FIELD     6:0
`define RSAC_QW_FIELD        7:4
`define RSAC_AW_FIELD        3:0
`define RSAC_CW_FIELD        7:6
`define RSAC_RW_FIELD        5:4
`define RSAC_FIELD_IRQ_BIT   0
`define RSAC_RF_IRQ_FIELD    2:1
`define RSAC_PROTO_AUTO      2'h0
`define RSAC_PROTO_RESV      2'h3
`define RSAC_IRQ_NONE        2'h0
`define RSAC_IRQ_RESV        2'h1
`define RSAC_SLAVE_DEF       7'h54
`define RSAC_QW_DEF          4'h4
`define RSAC_QW_MAX          4'h8
`define RSAC_AW_DEF          4'h7
`define RSAC_AW_MAX          4'hc
`define RSAC_CW_DEF          2'h3
`define RSAC_RW_DEF          2'h3
`define RSAC_WORD_LO_DEF     8'h00
`define RSAC_WORD_HI_DEF     8'h54
`define RSAC_TUNNEL_DEF      8'h47
`define RSAC_HOST_DEF        8'hf0
`define RSAC_WORD_LO_MASK    8'h31
`define RSAC_WORD_HI_MASK    8'h7f
`define RSAC_HOST_MASK       8'hf7
`define RSAC_EXP_PAD         2'h0
`define RSAC_CLK_NS          40
`define RSAC_TUN_T_NS        1024000
`define RSAC_CHAR_T_NS       942000
`define RSAC_RESP_T_NS       1880000
`endif

//--- pkg/rsac_pkg.sv
// Types shared by the configuration loader modules
package rsac_pkg;
  typedef enum logic [1:0] {
    RSAC_T_IDLE = 2'b01,
    RSAC_T_RUN  = 2'b10
  } rsac_tstate_t;

  typedef struct packed {
    logic [1:0] proto;
    logic       id_sa;
    logic [6:0] slave;
    logic [3:0] qw;
    logic [3:0] aw;
    logic [1:0] cw;
    logic [1:0] rw;
    logic       field_irq;
    logic [1:0] rf_irq;
  } rsac_cfg_t;

  typedef struct packed {
    logic       req;
    logic [4:0] block;
    logic       write;
    logic       plain;
  } rsac_acc_t;

  typedef struct packed {
    logic ack;
    logic allow;
    logic ro_deny;
    logic plain_deny;
  } rsac_ans_t;
endpackage

//--- src/rsac_block_bit.sv
// Per-block bit lookup in a lock vector
`timescale 1ns/1ps
`default_nettype none
module rsac_block_bit #(
  parameter int N = 27
) (
  // Lock vector and block index
  input  wire logic [N-1:0] bits_i,
  input  wire logic [4:0]   block_i,
  // Selected bit
  output logic              bit_o
);
  // System-area blocks carry no lock bit and read as unlocked
  assign bit_o = (block_i < 5'(N)) ? bits_i[block_i] : 1'b0;
endmodule // rsac_block_bit
`default_nettype wire

//--- src/rsac_wait_timer.sv
// Wait timer of base period times two to a power
`timescale 1ns/1ps
`default_nettype none
module rsac_wait_timer
  import rsac_pkg::*;
#(
  parameter int BASE_W = 16,
  parameter int TICK_W = 13
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // Control
  input  wire logic              start_i,
  input  wire logic              stop_i,
  input  wire logic [BASE_W-1:0] base_i,
  input  wire logic [3:0]        exp_i,
  // Status
  output logic                   expired_o,
  output logic                   running_o
);
  rsac_tstate_t      state;
  rsac_tstate_t      next_state;
  logic [BASE_W-1:0] pre;
  logic [BASE_W-1:0] next_pre;
  logic [TICK_W-1:0] tick;
  logic [TICK_W-1:0] next_tick;
  logic              next_expired;
  logic [TICK_W-1:0] limit;

  assign running_o = (state == RSAC_T_RUN);

  always_comb begin
    limit        = (TICK_W'(1) << exp_i) - TICK_W'(1);
    next_state   = state;
    next_pre     = pre;
    next_tick    = tick;
    next_expired = 1'b0;
    case (state)
      RSAC_T_IDLE: begin
        if (start_i) begin
          next_state = RSAC_T_RUN;
          next_pre   = '0;
          next_tick  = '0;
        end
      end
      RSAC_T_RUN: begin
        // A restart wins over a stop in the same cycle
        if (start_i) begin
          next_pre  = '0;
          next_tick = '0;
        end else if (stop_i) begin
          next_state = RSAC_T_IDLE;
        end else if (pre == base_i - BASE_W'(1)) begin
          next_pre = '0;
          if (tick == limit) begin
            next_expired = 1'b1;
            next_state   = RSAC_T_IDLE;
          end else begin
            next_tick = tick + TICK_W'(1);
          end
        end else begin
          next_pre = pre + BASE_W'(1);
        end
      end
      default: next_state = RSAC_T_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= RSAC_T_IDLE;
      pre       <= '0;
      tick      <= '0;
      expired_o <= 1'b0;
    end else begin
      state     <= next_state;
      pre       <= next_pre;
      tick      <= next_tick;
      expired_o <= next_expired;
    end
  end

  expire_cause_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    expired_o |-> $past(running_o) && !running_o && $past(tick) == $past(limit))
    else $error("timer expired without a full count");
endmodule // rsac_wait_timer
`default_nettype wire

//--- testbench/rsac_host_model.sv
// Host-side model that drives the system-area byte port
`timescale 1ns/1ps
`default_nettype none
module rsac_host_model (
  // Clock and bench commands
  input  wire logic       sys_clk_i,
  input  wire logic       wr_go_i,
  input  wire logic       rd_go_i,
  input  wire logic       raw_i,
  input  wire logic [8:0] addr_i,
  input  wire logic [7:0] data_i,
  // Store port
  output logic            sa_wr_o,
  output logic            sa_rd_o,
  output logic      [8:0] sa_addr_o,
  output logic      [7:0] sa_wdata_o
);
  logic       idle_q = 1'b0;
  logic [7:0] keep;
  always @(posedge sys_clk_i) idle_q <= ~idle_q;
  always_comb begin
    case (addr_i)
      9'h1f3, 9'h1f7, 9'h1fb: keep = 8'h07;
      9'h1ee:                 keep = 8'h31;
      9'h1ef:                 keep = 8'h7f;
      9'h1fd:                 keep = 8'hf7;
      default:                keep = 8'hff;
    endcase
  end
  assign sa_wr_o    = wr_go_i;
  assign sa_rd_o    = rd_go_i;
  assign sa_addr_o  = addr_i;
  // Idle data toggles so a stale byte never looks like a write
  assign sa_wdata_o = wr_go_i ? (raw_i ? data_i : data_i & keep) : {8{idle_q}};
endmodule // rsac_host_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsac_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic       wr_go, rd_go, raw, cfg_valid, self_rst;
  logic [8:0] addr, sa_addr;
  logic [7:0] data, sa_wdata, sa_rdata;
  logic       sa_wr, sa_rd, sa_rvalid;
  rsac_acc_t  rf_acc, si_acc;
  rsac_ans_t  rf_ans, si_ans;
  rsac_cfg_t  cfg;
  logic [3:0] go, halt, tmo;
  int         fails = 0;
  int         compares = 0;
  int         cycles = 0;
  localparam rsac_cfg_t DEF = {2'h0, 1'h0, 7'h54, 4'h4, 4'h7, 2'h3, 2'h3, 1'h0, 2'h0};
  // Rows: rf, block, write, plain, expected {ack, allow, ro_deny, plain_deny}
  logic [11:0] rows [10] = '{
    {1'h1, 5'h1a, 1'h1, 1'h0, 4'ha}, {1'h1, 5'h1a, 1'h0, 1'h0, 4'hc},
    {1'h1, 5'h00, 1'h1, 1'h0, 4'ha}, {1'h1, 5'h01, 1'h1, 1'h0, 4'hc},
    {1'h1, 5'h17, 1'h0, 1'h1, 4'h9}, {1'h1, 5'h17, 1'h1, 1'h0, 4'hc},
    {1'h0, 5'h18, 1'h1, 1'h0, 4'ha}, {1'h0, 5'h17, 1'h1, 1'h1, 4'hc},
    {1'h0, 5'h00, 1'h1, 1'h0, 4'hc}, {1'h1, 5'h18, 1'h1, 1'h0, 4'hc}};

  always #20 sys_clk_i = ~sys_clk_i;

  rsac_host_model rsac_host_model_inst (
    .sys_clk_i(sys_clk_i), .wr_go_i(wr_go), .rd_go_i(rd_go), .raw_i(raw),
    .addr_i(addr), .data_i(data), .sa_wr_o(sa_wr), .sa_rd_o(sa_rd),
    .sa_addr_o(sa_addr), .sa_wdata_o(sa_wdata));

  rsac_top #(.TUN_BASE_CYC(4), .CHAR_BASE_CYC(4), .RESP_BASE_CYC(4)) rsac_top_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sa_wr_i(sa_wr), .sa_rd_i(sa_rd),
    .sa_addr_i(sa_addr), .sa_wdata_i(sa_wdata), .sa_rdata_o(sa_rdata),
    .sa_rvalid_o(sa_rvalid), .cfg_valid_i(cfg_valid), .self_reset_i(self_rst),
    .rf_acc_i(rf_acc), .rf_ans_o(rf_ans), .si_acc_i(si_acc), .si_ans_o(si_ans),
    .cfg_o(cfg), .tun_irq_sent_i(go[0]), .tun_tunnel_poll_command_i(halt[0]),
    .tun_tunnel_poll_command_done_i(go[1]), .tun_answer_i(halt[1]), .tunnel_poll_command_timeout_o(tmo[0]),
    .answer_timeout_o(tmo[1]), .i2c_char_i(go[2]), .i2c_end_i(halt[2]),
    .resp_start_i(go[3]), .read_req_i(halt[3]), .char_timeout_o(tmo[2]),
    .resp_timeout_o(tmo[3]));

  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    addr = a;
    data = d;
    wr_go = 1'b1;
    @(negedge sys_clk_i);
    wr_go = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    addr = a;
    rd_go = 1'b1;
    @(negedge sys_clk_i);
    rd_go = 1'b0;
    chk(sa_rvalid, 1);
    chk(sa_rdata, e);
    @(negedge sys_clk_i);
  endtask

  task automatic acc(input logic rf, input logic [4:0] b, input logic w, input logic p,
                     input logic [3:0] e);
    if (rf) rf_acc = '{1'b1, b, w, p};
    else si_acc = '{1'b1, b, w, p};
    @(negedge sys_clk_i);
    rf_acc.req = 1'b0;
    si_acc.req = 1'b0;
    chk(rf ? rf_ans : si_ans, e);
    @(negedge sys_clk_i);
  endtask

  task automatic reload();
    self_rst = 1'b1;
    @(negedge sys_clk_i);
    self_rst = 1'b0;
    @(negedge sys_clk_i);
  endtask

  // Start timer k, optionally stop it one cycle later; expect pulse after n cycles
  task automatic tmr(input int k, input int n, input logic cut);
    go[k] = 1'b1;
    @(negedge sys_clk_i);
    go[k] = 1'b0;
    halt[k] = cut;
    for (int i = 1; i <= n + 1; i++) begin
      @(negedge sys_clk_i);
      halt[k] = 1'b0;
      chk(tmo[k], i == n && !cut);
    end
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end

  initial begin
    logic       rf, w, p;
    logic [4:0] b;
    logic [3:0] e;
    {wr_go, rd_go, raw, self_rst, go, halt, addr, data} = '0;
    cfg_valid = 1'b1;
    rf_acc = '0;
    si_acc = '0;
    repeat (5) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    chk(cfg, DEF);
    rd(9'h1ee, 8'h00);
    rd(9'h1ef, 8'h54);
    rd(9'h1f0, 8'h00);
    rd(9'h1f4, 8'h00);
    rd(9'h1f8, 8'h00);
    rd(9'h1fc, 8'h47);
    rd(9'h1fd, 8'hf0);
    rd(9'h000, 8'h00);
    raw = 1'b1;
    wr(9'h1f3, 8'hff);
    raw = 1'b0;
    rd(9'h1f3, 8'h07);
    wr(9'h1f3, 8'h04);
    wr(9'h1f0, 8'h01);
    wr(9'h1f7, 8'h01);
    wr(9'h1fa, 8'h80);
    for (int i = 0; i < 10; i++) begin
      {rf, b, w, p, e} = rows[i];
      acc(rf, b, w, p, e);
    end
    cfg_valid = 1'b0;
    acc(1'b1, 5'h1a, 1'b1, 1'b0, 4'hc);
    cfg_valid = 1'b1;
    wr(9'h1ef, 8'h2a);
    wr(9'h1fc, 8'h9d);
    wr(9'h1fd, 8'ha3);
    chk(cfg, DEF);
    for (int q = 0; q < 4; q++) begin
      wr(9'h1ee, {2'h0, q[1:0], 3'h0, 1'h1});
      reload();
      chk(cfg.proto, (q == 3) ? 0 : q);
    end
    chk(cfg, {2'h0, 1'h1, 7'h2a, 4'h4, 4'h7, 2'h2, 2'h2, 1'h1, 2'h0});
    wr(9'h1fc, 8'h8c);
    wr(9'h1fd, 8'h55);
    reload();
    chk(cfg, {2'h0, 1'h1, 7'h2a, 4'h8, 4'hc, 2'h1, 2'h1, 1'h1, 2'h2});
    wr(9'h1fc, 8'h01);
    wr(9'h1fd, 8'h1e);
    rd(9'h1fd, 8'h16);
    reload();
    chk(cfg, {2'h0, 1'h1, 7'h2a, 4'h0, 4'h1, 2'h0, 2'h1, 1'h0, 2'h3});
    tmr(0, 4, 1'b0);
    tmr(0, 4, 1'b1);
    tmr(1, 8, 1'b0);
    tmr(1, 8, 1'b1);
    tmr(2, 4, 1'b0);
    tmr(2, 4, 1'b1);
    tmr(3, 8, 1'b0);
    tmr(3, 8, 1'b1);
    cfg_valid = 1'b0;
    reload();
    chk(cfg, DEF);
    tmr(0, 64, 1'b0);
    // Mid-run reset must clear locks and restore stored defaults
    resetn_i = 1'b0;
    cfg_valid = 1'b1;
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    chk(cfg, DEF);
    rd(9'h1f0, 8'h00);
    rd(9'h1fc, 8'h47);
    results();
  end
endmodule // tb
`default_nettype wire
